// >>> hdl/tmps_port_sel.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Eight trunks, up to four members each
// - Hash SA+DA default; SA or DA selectable
// - Source-port hash only in ring mode
// - Multicast uses the same hash key
// - Trunk-flagged destination fetches its group number
// - Trunk-flagged unicast from a member of dest trunk dropped
// - Eight select entries per trunk, key-indexed
// - Hash deterministic per address pair
// - Multicast drops source port and its trunk
// - Multicast keeps one hashed member per trunk
// - Software reprograms entries; applied at once
// - Source MAC mirror flag copies to mirror
// - Destination MAC mirror flag copies to mirror
// - Flow pair match copies to mirror
// - Optional reversed flow pair match
// - Port ingress or egress copied to mirror
// - At most two mirror ports
// - Mirror ports carry only mirrored copies
module tmps_port_sel
  import tmps_pkg::*;
#(
  parameter int MAXMEMB = 4
) (
  input  wire logic             CLK_IN,
  input  wire logic             RST_IN,
  input  wire logic             PSEL_IN,
  input  wire logic             PENABLE_IN,
  input  wire logic             PWRITE_IN,
  input  wire logic [AW-1:0]    PADDR_IN,
  input  wire logic [DW-1:0]    PWDATA_IN,
  output logic      [DW-1:0]    PRDATA_OUT,
  output logic                  PREADY_OUT,
  output logic                  PSLVERR_OUT,
  input  wire logic             REQ_VALID_IN,
  input  wire logic             REQ_MCAST_IN,
  input  wire logic [PW-1:0]    REQ_SRC_PORT_IN,
  input  wire logic [47:0]      REQ_SA_IN,
  input  wire logic [47:0]      REQ_DA_IN,
  input  wire logic [NPORT-1:0] REQ_DEST_IN,
  input  wire logic             REQ_DST_TRUNK_IN,
  input  wire logic             REQ_SA_MIRROR_IN,
  input  wire logic             REQ_DA_MIRROR_IN,
  output logic                  RES_VALID_OUT,
  output logic      [NPORT-1:0] RES_DEST_OUT,
  output logic                  RES_DROP_OUT,
  output logic                  RES_MIRRORED_OUT
);

  // Software-visible configuration
  logic [6:0]       ctrl_q;
  logic [10:0]      mir_q [2];
  logic [47:0]      fsa_q;
  logic [47:0]      fda_q;

  // Trunk tables; cleared so no port starts out trunked
  logic [NPORT-1:0] memb_q [NTRUNK];
  logic [PW-1:0]    sel_q [NTRUNK][NSEL];

  // Status counters wrap silently and have no clear
  logic [CW-1:0]    drop_cnt_q;
  logic [CW-1:0]    mir_cnt_q;

  // Bus answer, always one wait-free access cycle
  logic [DW-1:0]    prdata_q;
  logic             pready_q;
  logic             pslverr_q;

  // Decision result, one cycle after the request
  logic             res_valid_q;
  logic [NPORT-1:0] res_dest_q;
  logic             res_drop_q;
  logic             res_mir_q;

  // Fold a 48-bit value to a key; pure function of its input so a flow
  // always hashes to the same entry
  function automatic logic [KW-1:0] fold48(input logic [47:0] v);
    logic [KW-1:0] k;
    k = '0;
    for (int i = 0; i < 16; i++) begin
      k = k ^ v[i*KW +: KW];
    end
    return k;
  endfunction : fold48

  // APB decode
  // The answer is fixed one cycle after setup, so the access phase
  // never stretches; a write commits only in that access cycle
  wire         setup_ph  = PSEL_IN & ~PENABLE_IN;
  wire         wr_fire   = PSEL_IN & PENABLE_IN & pready_q & PWRITE_IN & ~pslverr_q;
  wire         is_memb   = (PADDR_IN[AW-1:5] == MEMB_BASE[AW-1:5]);
  wire         is_sel    = (PADDR_IN[AW-1:5] == SEL_BASE[AW-1:5]);
  wire [TW-1:0] reg_tidx = PADDR_IN[2+TW-1:2];
  wire         aligned   = (PADDR_IN[1:0] == 2'h0);
  wire         is_ctrl   = (PADDR_IN == CTRL_OFS);
  wire         is_mir0   = (PADDR_IN == MIR0_OFS);
  wire         is_mir1   = (PADDR_IN == MIR1_OFS);
  wire         is_fsal   = (PADDR_IN == FSA_LO_OFS);
  wire         is_fsah   = (PADDR_IN == FSA_HI_OFS);
  wire         is_fdal   = (PADDR_IN == FDA_LO_OFS);
  wire         is_fdah   = (PADDR_IN == FDA_HI_OFS);
  wire         is_stat   = (PADDR_IN == STAT_OFS);
  wire         mapped    = aligned & (is_ctrl | is_mir0 | is_mir1 | is_fsal | is_fsah |
                                      is_fdal | is_fdah | is_stat | is_memb | is_sel);
  // Status is read-only; a write to it is refused with an error
  wire         bad_acc   = ~mapped | (is_stat & PWRITE_IN);

  logic [DW-1:0] sel_word;
  always_comb begin
    sel_word = '0;
    for (int e = 0; e < NSEL; e++) begin
      sel_word[e*PW +: PW] = sel_q[reg_tidx][e];
    end
  end

  wire [DW-1:0] rd_mux =
    is_ctrl ? {25'h0000000, ctrl_q} :
    is_mir0 ? {21'h000000, mir_q[0]} :
    is_mir1 ? {21'h000000, mir_q[1]} :
    is_fsal ? fsa_q[31:0] :
    is_fsah ? {16'h0000, fsa_q[47:32]} :
    is_fdal ? fda_q[31:0] :
    is_fdah ? {16'h0000, fda_q[47:32]} :
    is_stat ? {mir_cnt_q, drop_cnt_q} :
    is_memb ? {{(DW-NPORT){1'b0}}, memb_q[reg_tidx]} :
    is_sel  ? sel_word : 32'h00000000;

  // Config fields
  wire [1:0] hash_sel = ctrl_q[CTRL_HASH_LSB +: 2];
  wire       ring_en  = ctrl_q[CTRL_RING_BIT];
  wire       am_dst   = ctrl_q[CTRL_AMDST_BIT];
  wire       am_en    = ctrl_q[CTRL_AMEN_BIT];
  wire       fm_en    = ctrl_q[CTRL_FMEN_BIT];
  wire       fm_rev   = ctrl_q[CTRL_FMREV_BIT];

  // Hash key, shared by unicast and multicast
  // Source-port keying falls back to the address hash outside ring
  // mode, so a stray mode setting cannot skew distribution
  logic [KW-1:0] key;
  always_comb begin
    case (hash_sel)
      TMPS_HASH_SA:   key = fold48(REQ_SA_IN);
      TMPS_HASH_DA:   key = fold48(REQ_DA_IN);
      TMPS_HASH_PORT: key = ring_en ? REQ_SRC_PORT_IN[KW-1:0] : fold48(REQ_SA_IN ^ REQ_DA_IN);
      default:        key = fold48(REQ_SA_IN ^ REQ_DA_IN);
    endcase
  end

  // Mirror ports and their one-hot masks
  // A port number beyond the last port selects nothing, so a bad
  // setting loses the copy rather than hitting a wrong port
  logic [NPORT-1:0] mport_oh [2];
  logic [NPORT-1:0] mon_oh [2];
  logic [NPORT-1:0] mport_all;
  always_comb begin
    mport_all = '0;
    for (int m = 0; m < 2; m++) begin
      mport_oh[m] = '0;
      mon_oh[m] = '0;
      if (mir_q[m][MIR_EN_BIT]) begin
        mport_oh[m][mir_q[m][MIR_PORT_LSB +: PW]] = 1'b1;
        mon_oh[m][mir_q[m][MIR_MON_LSB +: PW]] = 1'b1;
      end
      mport_all = mport_all | mport_oh[m];
    end
  end

  // Trunk resolution
  // Source group is the ingress port plus every member of its trunk;
  // multicast must never echo back onto that group
  // Trunk-flagged unicast to a trunk member is replaced by the hashed member, and
  // dropped outright when the ingress port sits in the same trunk
  // An entry naming a non-member keeps no port of that trunk, which
  // is how software parks a failed link until it reprograms
  logic [NPORT-1:0] src_oh;
  logic [NPORT-1:0] src_grp;
  logic [NPORT-1:0] fwd;
  logic             drop;
  logic [NPORT-1:0] pick_oh;
  always_comb begin
    src_oh = '0;
    src_oh[REQ_SRC_PORT_IN] = 1'b1;
    src_grp = src_oh;
    for (int t = 0; t < NTRUNK; t++) begin
      if ((memb_q[t] & src_oh) != '0) begin
        src_grp = src_grp | memb_q[t];
      end
    end
    drop = 1'b0;
    fwd = REQ_DEST_IN;
    if (REQ_MCAST_IN) begin
      fwd = fwd & ~src_grp;
      for (int t = 0; t < NTRUNK; t++) begin
        pick_oh = '0;
        pick_oh[sel_q[t][key]] = 1'b1;
        if ((fwd & memb_q[t]) != '0) begin
          fwd = (fwd & ~memb_q[t]) | (pick_oh & memb_q[t]);
        end
      end
    end else if (REQ_DST_TRUNK_IN) begin
      for (int t = 0; t < NTRUNK; t++) begin
        pick_oh = '0;
        pick_oh[sel_q[t][key]] = 1'b1;
        if ((REQ_DEST_IN & memb_q[t]) != '0) begin
          fwd = pick_oh;
          if ((memb_q[t] & src_oh) != '0) begin
            drop = 1'b1;
          end
        end
      end
    end
    pick_oh = '0;
  end

  wire [NPORT-1:0] fwd_norm = drop ? '0 : (fwd & ~mport_all);

  // Mirror decisions
  wire addr_hit = am_en & (am_dst ? REQ_DA_MIRROR_IN : REQ_SA_MIRROR_IN);
  wire flow_fwd = (REQ_SA_IN == fsa_q) & (REQ_DA_IN == fda_q);
  wire flow_rev = fm_rev & (REQ_SA_IN == fda_q) & (REQ_DA_IN == fsa_q);
  wire flow_hit = fm_en & (flow_fwd | flow_rev);

  // Address and flow copies use the first mirror port only
  logic [NPORT-1:0] mir_mask;
  always_comb begin
    mir_mask = '0;
    if (addr_hit | flow_hit) begin
      mir_mask = mport_oh[0];
    end
    for (int m = 0; m < 2; m++) begin
      if ((mir_q[m][MIR_ING_BIT] & ((mon_oh[m] & src_oh) != '0)) |
          (mir_q[m][MIR_EGR_BIT] & ((mon_oh[m] & fwd_norm) != '0))) begin
        mir_mask = mir_mask | mport_oh[m];
      end
    end
  end

  // OR into one mask so a port hit by several conditions gets one copy
  wire [NPORT-1:0] final_dest = fwd_norm | mir_mask;

  // APB register
  // Read data is zero outside a good read so the bus shows nothing
  // stale between transfers
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= setup_ph;
      pslverr_q <= setup_ph & bad_acc;
      prdata_q  <= (setup_ph & ~PWRITE_IN & ~bad_acc) ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      ctrl_q  <= CTRL_RST;
      mir_q[0] <= MIR_RST;
      mir_q[1] <= MIR_RST;
      fsa_q   <= 48'h000000000000;
      fda_q   <= 48'h000000000000;
    end else if (wr_fire) begin
      // Each half of a flow address lands alone; software should
      // disable flow mirroring while it rewrites a pair
      if (is_ctrl) begin
        ctrl_q <= PWDATA_IN[6:0];
      end
      if (is_mir0) begin
        mir_q[0] <= PWDATA_IN[10:0];
      end
      if (is_mir1) begin
        mir_q[1] <= PWDATA_IN[10:0];
      end
      if (is_fsal) begin
        fsa_q[31:0] <= PWDATA_IN;
      end
      if (is_fsah) begin
        fsa_q[47:32] <= PWDATA_IN[15:0];
      end
      if (is_fdal) begin
        fda_q[31:0] <= PWDATA_IN;
      end
      if (is_fdah) begin
        fda_q[47:32] <= PWDATA_IN[15:0];
      end
    end
  end

  // Member table: writes with more than MAXMEMB bits set are ignored
  wire memb_ok = ($countones(PWDATA_IN[NPORT-1:0]) <= MAXMEMB);
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      for (int t = 0; t < NTRUNK; t++) begin
        memb_q[t] <= '0;
        for (int e = 0; e < NSEL; e++) begin
          sel_q[t][e] <= '0;
        end
      end
    end else if (wr_fire) begin
      // An oversized group is refused whole rather than trimmed
      if (is_memb & memb_ok) begin
        memb_q[reg_tidx] <= PWDATA_IN[NPORT-1:0];
      end
      if (is_sel) begin
        for (int e = 0; e < NSEL; e++) begin
          sel_q[reg_tidx][e] <= PWDATA_IN[e*PW +: PW];
        end
      end
    end
  end

  // Any mirror copy at all marks the frame as mirrored
  wire req_mir = (mir_mask != '0);

  // Result pipeline and counters
  // Outputs fall back to zero between requests so a consumer that
  // ignores the valid pulse still sees nothing
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      res_valid_q <= 1'b0;
      res_dest_q  <= '0;
      res_drop_q  <= 1'b0;
      res_mir_q   <= 1'b0;
      drop_cnt_q  <= '0;
      mir_cnt_q   <= '0;
    end else begin
      res_valid_q <= REQ_VALID_IN;
      res_dest_q  <= REQ_VALID_IN ? final_dest : '0;
      res_drop_q  <= REQ_VALID_IN & drop;
      res_mir_q   <= REQ_VALID_IN & req_mir;
      if (REQ_VALID_IN & drop) begin
        drop_cnt_q <= drop_cnt_q + 16'h0001;
      end
      if (REQ_VALID_IN & req_mir) begin
        mir_cnt_q <= mir_cnt_q + 16'h0001;
      end
    end
  end

  // Every output comes straight from a flip-flop
  assign PRDATA_OUT       = prdata_q;
  assign PREADY_OUT       = pready_q;
  assign PSLVERR_OUT      = pslverr_q;
  assign RES_VALID_OUT    = res_valid_q;
  assign RES_DEST_OUT     = res_dest_q;
  assign RES_DROP_OUT     = res_drop_q;
  assign RES_MIRRORED_OUT = res_mir_q;

endmodule : tmps_port_sel
`default_nettype wire

// >>> hdl/tmps_pkg.sv
package tmps_pkg;
  localparam int NPORT = 10;
  localparam int NTRUNK = 8;
  localparam int NSEL = 8;
  localparam int PW = 4;
  localparam int TW = 3;
  localparam int KW = 3;
  localparam int AW = 12;
  localparam int DW = 32;
  localparam int CW = 16;
  localparam logic [AW-1:0] CTRL_OFS = 12'h000;
  localparam logic [AW-1:0] MIR0_OFS = 12'h008;
  localparam logic [AW-1:0] MIR1_OFS = 12'h00C;
  localparam logic [AW-1:0] FSA_LO_OFS = 12'h010;
  localparam logic [AW-1:0] FSA_HI_OFS = 12'h014;
  localparam logic [AW-1:0] FDA_LO_OFS = 12'h018;
  localparam logic [AW-1:0] FDA_HI_OFS = 12'h01C;
  localparam logic [AW-1:0] STAT_OFS = 12'h020;
  localparam logic [AW-1:0] MEMB_BASE = 12'h040;
  localparam logic [AW-1:0] SEL_BASE = 12'h080;
  typedef enum logic [1:0] {
    TMPS_HASH_SADA = 2'h0,
    TMPS_HASH_SA   = 2'h1,
    TMPS_HASH_DA   = 2'h2,
    TMPS_HASH_PORT = 2'h3
  } tmps_hash_t;
  localparam int CTRL_HASH_LSB = 0;
  localparam int CTRL_RING_BIT = 2;
  localparam int CTRL_AMDST_BIT = 3;
  localparam int CTRL_AMEN_BIT = 4;
  localparam int CTRL_FMEN_BIT = 5;
  localparam int CTRL_FMREV_BIT = 6;
  localparam int MIR_PORT_LSB = 0;
  localparam int MIR_MON_LSB = 4;
  localparam int MIR_ING_BIT = 8;
  localparam int MIR_EGR_BIT = 9;
  localparam int MIR_EN_BIT = 10;
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [10:0] MIR_RST = 11'h000;
endpackage : tmps_pkg

// >>> test/tmps_port_sel_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module tmps_port_sel_monitor
  import tmps_pkg::*;
(
  input wire logic             CLK_IN,
  input wire logic             RST_IN,
  input wire logic             PSEL_IN,
  input wire logic             PENABLE_IN,
  input wire logic [AW-1:0]    PADDR_IN,
  input wire logic             PREADY_OUT,
  input wire logic             PSLVERR_OUT,
  input wire logic [DW-1:0]    PRDATA_OUT,
  input wire logic             REQ_VALID_IN,
  input wire logic             REQ_MCAST_IN,
  input wire logic             RES_VALID_OUT,
  input wire logic [NPORT-1:0] RES_DEST_OUT,
  input wire logic             RES_DROP_OUT,
  input wire logic             RES_MIRRORED_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  property p_rdy; PSEL_IN && !PENABLE_IN |=> PREADY_OUT; endproperty
  property p_rdy_src; PREADY_OUT |-> $past(PSEL_IN && !PENABLE_IN); endproperty
  property p_bad; PSEL_IN && !PENABLE_IN && PADDR_IN == 12'h004 |=> PSLVERR_OUT; endproperty
  property p_err; PSLVERR_OUT |-> PREADY_OUT && PRDATA_OUT == '0; endproperty
  property p_lat; REQ_VALID_IN |=> RES_VALID_OUT; endproperty
  property p_once; RES_VALID_OUT |-> $past(REQ_VALID_IN); endproperty
  property p_idle; !RES_VALID_OUT |-> RES_DEST_OUT == '0 && !RES_DROP_OUT && !RES_MIRRORED_OUT; endproperty
  // A drop still lets mirror copies through, so only a bare mask must be empty
  property p_drop; RES_DROP_OUT |-> !$past(REQ_MCAST_IN) && (RES_DEST_OUT == '0 || RES_MIRRORED_OUT); endproperty
  property p_mir; RES_MIRRORED_OUT |-> RES_DEST_OUT != '0; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  a_rdy_src: assert property (p_rdy_src) else $error("ready without setup");
  a_bad: assert property (p_bad) else $error("unmapped access not refused");
  a_err: assert property (p_err) else $error("error without ready or with data");
  a_lat: assert property (p_lat) else $error("request not answered");
  a_once: assert property (p_once) else $error("answer without request");
  a_idle: assert property (p_idle) else $error("result outputs busy while idle");
  a_drop: assert property (p_drop) else $error("bad drop");
  a_mir: assert property (p_mir) else $error("mirror flag with empty mask");
  c_drop: cover property (RES_DROP_OUT);
  c_mir: cover property (RES_MIRRORED_OUT);
  c_err: cover property (PSLVERR_OUT);
endmodule : tmps_port_sel_monitor
bind tmps_port_sel tmps_port_sel_monitor mon_u (.CLK_IN, .RST_IN, .PSEL_IN, .PENABLE_IN, .PADDR_IN, .PREADY_OUT,
  .PSLVERR_OUT, .PRDATA_OUT, .REQ_VALID_IN, .REQ_MCAST_IN, .RES_VALID_OUT, .RES_DEST_OUT, .RES_DROP_OUT,
  .RES_MIRRORED_OUT);
`default_nettype wire

// >>> test/tmps_engine_model.sv
`timescale 1ns/10ps
`default_nettype none
module tmps_engine_model
  import tmps_pkg::*;
(
  input  wire logic             CLK_IN,
  output logic                  REQ_VALID_OUT,
  output logic                  REQ_MCAST_OUT,
  output logic      [PW-1:0]    REQ_SRC_OUT,
  output logic      [47:0]      REQ_SA_OUT,
  output logic      [47:0]      REQ_DA_OUT,
  output logic      [NPORT-1:0] REQ_DEST_OUT,
  output logic                  REQ_TRUNK_OUT,
  output logic                  REQ_SAM_OUT,
  output logic                  REQ_DAM_OUT
);
  logic [PW+NPORT+99:0] fld_q;
  assign {REQ_MCAST_OUT, REQ_SRC_OUT, REQ_SA_OUT, REQ_DA_OUT, REQ_DEST_OUT, REQ_TRUNK_OUT, REQ_SAM_OUT,
          REQ_DAM_OUT} = fld_q;
  initial begin
    REQ_VALID_OUT = 1'b0;
    fld_q = '0;
  end
  task automatic send(input logic [PW+NPORT+99:0] f);
    @(posedge CLK_IN);
    REQ_VALID_OUT <= 1'b1;
    fld_q <= f;
    @(posedge CLK_IN);
    REQ_VALID_OUT <= 1'b0;
    // Stale fields are inverted so a late sample can never match by luck
    fld_q <= ~f;
  endtask : send
endmodule : tmps_engine_model
`default_nettype wire

// >>> test/trunk_and_mirror_port_select_tb.sv
`timescale 1ns/10ps
`default_nettype none
module trunk_and_mirror_port_select_tb
  import tmps_pkg::*;
  ;
  logic             CLK_IN = 1'b0, RST_IN = 1'b1, PSEL_IN = 1'b0, PENABLE_IN = 1'b0, PWRITE_IN = 1'b0;
  logic [AW-1:0]    PADDR_IN = '0;
  logic [DW-1:0]    PWDATA_IN = '0, PRDATA_OUT, rd;
  logic             PREADY_OUT, PSLVERR_OUT, REQ_VALID_IN, REQ_MCAST_IN, REQ_DST_TRUNK_IN, er;
  logic             REQ_SA_MIRROR_IN, REQ_DA_MIRROR_IN, RES_VALID_OUT, RES_DROP_OUT, RES_MIRRORED_OUT;
  logic [PW-1:0]    REQ_SRC_PORT_IN;
  logic [47:0]      REQ_SA_IN, REQ_DA_IN;
  logic [NPORT-1:0] REQ_DEST_IN, RES_DEST_OUT;
  int               fail_count = 0, n_tests = 0;
  tmps_port_sel dut_u (.CLK_IN, .RST_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PRDATA_OUT,
    .PREADY_OUT, .PSLVERR_OUT, .REQ_VALID_IN, .REQ_MCAST_IN, .REQ_SRC_PORT_IN, .REQ_SA_IN, .REQ_DA_IN,
    .REQ_DEST_IN, .REQ_DST_TRUNK_IN, .REQ_SA_MIRROR_IN, .REQ_DA_MIRROR_IN, .RES_VALID_OUT, .RES_DEST_OUT,
    .RES_DROP_OUT, .RES_MIRRORED_OUT);
  tmps_engine_model eng_u (.CLK_IN, .REQ_VALID_OUT(REQ_VALID_IN), .REQ_MCAST_OUT(REQ_MCAST_IN),
    .REQ_SRC_OUT(REQ_SRC_PORT_IN), .REQ_SA_OUT(REQ_SA_IN), .REQ_DA_OUT(REQ_DA_IN), .REQ_DEST_OUT(REQ_DEST_IN),
    .REQ_TRUNK_OUT(REQ_DST_TRUNK_IN), .REQ_SAM_OUT(REQ_SA_MIRROR_IN), .REQ_DAM_OUT(REQ_DA_MIRROR_IN));
  initial forever #4 CLK_IN = ~CLK_IN;
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge CLK_IN);
    PSEL_IN <= 1'b1;
    PENABLE_IN <= 1'b0;
    PWRITE_IN <= w;
    PADDR_IN <= a;
    PWDATA_IN <= d;
    @(posedge CLK_IN);
    PENABLE_IN <= 1'b1;
    @(posedge CLK_IN);
    while (PREADY_OUT !== 1'b1) @(posedge CLK_IN);
    rd = PRDATA_OUT;
    er = PSLVERR_OUT;
    PSEL_IN <= 1'b0;
    PENABLE_IN <= 1'b0;
  endtask : apb
  // Flags f: trunk, source mirror, destination mirror; r: drop, mirrored
  task automatic req(input logic m, input logic [3:0] s, input logic [47:0] sa, input logic [47:0] da,
                     input logic [9:0] dst, input logic [2:0] f, input logic [9:0] ex, input logic [1:0] r);
    eng_u.send({m, s, sa, da, dst, f});
    #1;
    chk(DW'({RES_VALID_OUT, RES_DROP_OUT, RES_MIRRORED_OUT, RES_DEST_OUT}), DW'({1'b1, r, ex}));
  endtask : req
  task automatic t_regs;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk(DW'(er), 32'h1);
    apb(1'b1, STAT_OFS, 32'h1);
    chk(DW'(er), 32'h1);
    apb(1'b1, MEMB_BASE + 12'h004, 32'h01F);
    apb(1'b0, MEMB_BASE + 12'h004, 32'h0);
    chk(rd, 32'h0);
    $display("regs done");
  endtask : t_regs
  task automatic t_hash;
    logic [6:0] m [5] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h07};
    logic [9:0] e [5] = '{10'h008, 10'h002, 10'h004, 10'h008, 10'h002};
    apb(1'b1, MEMB_BASE, 32'h00F);
    apb(1'b1, MEMB_BASE + 12'h004, 32'h060);
    apb(1'b1, SEL_BASE, 32'h32103210);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, CTRL_OFS, DW'(m[i]));
      req(1'b0, 4'h5, 48'h1, 48'h2, 10'h001, 3'h4, e[i], 2'h0);
      req(1'b0, 4'h5, 48'h1, 48'h2, 10'h001, 3'h4, e[i], 2'h0);
    end
    req(1'b0, 4'h2, 48'h1, 48'h2, 10'h001, 3'h4, 10'h000, 2'h2);
    apb(1'b1, CTRL_OFS, 32'h1);
    req(1'b1, 4'h5, 48'h1, 48'h2, 10'h3FF, 3'h0, 10'h392, 2'h0);
    apb(1'b1, SEL_BASE, 32'h0);
    req(1'b0, 4'h5, 48'h1, 48'h2, 10'h001, 3'h4, 10'h001, 2'h0);
    $display("hash done");
  endtask : t_hash
  task automatic t_mirror;
    apb(1'b1, MIR0_OFS, 32'h409);
    apb(1'b1, CTRL_OFS, 32'h10);
    req(1'b0, 4'h7, 48'h1, 48'h2, 10'h010, 3'h2, 10'h210, 2'h1);
    req(1'b0, 4'h7, 48'h1, 48'h2, 10'h010, 3'h1, 10'h010, 2'h0);
    apb(1'b1, CTRL_OFS, 32'h18);
    req(1'b0, 4'h7, 48'h1, 48'h2, 10'h010, 3'h1, 10'h210, 2'h1);
    req(1'b1, 4'h7, 48'h1, 48'h2, 10'h210, 3'h0, 10'h010, 2'h0);
    apb(1'b1, FSA_LO_OFS, 32'h1);
    apb(1'b1, FDA_LO_OFS, 32'h2);
    apb(1'b1, CTRL_OFS, 32'h20);
    req(1'b0, 4'h7, 48'h1, 48'h2, 10'h010, 3'h0, 10'h210, 2'h1);
    req(1'b0, 4'h7, 48'h2, 48'h1, 10'h010, 3'h0, 10'h010, 2'h0);
    apb(1'b1, CTRL_OFS, 32'h60);
    req(1'b0, 4'h7, 48'h2, 48'h1, 10'h010, 3'h0, 10'h210, 2'h1);
    apb(1'b1, CTRL_OFS, 32'h70);
    req(1'b0, 4'h7, 48'h1, 48'h2, 10'h010, 3'h2, 10'h210, 2'h1);
    $display("mirror done");
  endtask : t_mirror
  task automatic t_port;
    apb(1'b1, CTRL_OFS, 32'h0);
    apb(1'b1, MIR1_OFS, 32'h578);
    req(1'b0, 4'h7, 48'h1, 48'h2, 10'h010, 3'h0, 10'h110, 2'h1);
    apb(1'b1, MIR0_OFS, 32'h579);
    apb(1'b1, MIR1_OFS, 32'h648);
    req(1'b0, 4'h7, 48'h1, 48'h2, 10'h010, 3'h0, 10'h310, 2'h1);
    apb(1'b0, STAT_OFS, 32'h0);
    chk(rd, 32'h00070001);
    $display("port done");
  endtask : t_port
  task automatic finish_test;
    $display("checks=%0d fails=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (3) @(posedge CLK_IN);
    RST_IN <= 1'b0;
    t_regs();
    t_hash();
    t_mirror();
    t_port();
    finish_test();
  end
  // About 50 short transfers need under 3 us; the margin is generous
  initial begin
    #50000;
    fail_count++;
    finish_test();
  end
endmodule : trunk_and_mirror_port_select_tb
`default_nettype wire
